// ### src/edm_pkg.sv
// package: constants, opcodes and states for the extended data-memory datapath
package edm_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W     = 8;
  localparam int MEM_ADDR_W = 8;
  localparam int PROG_W     = 16;
  localparam int REG_ADDR_W = 3;
  localparam int FLAG_W     = 6;

  // ==========================================================================
  // register offsets
  localparam logic [2:0] REG_ACC        = 3'h0;
  localparam logic [2:0] REG_STATUS     = 3'h1;
  localparam logic [2:0] REG_TABLE_LOW  = 3'h2;
  localparam logic [2:0] REG_TABLE_HIGH = 3'h3;
  localparam logic [2:0] REG_TABLE_LATCH = 3'h4;

  // ==========================================================================
  // reset values
  localparam logic [7:0] ACC_RST         = 8'h00;
  localparam logic [5:0] STATUS_RST      = 6'h00;
  localparam logic [7:0] TABLE_LOW_RST   = 8'h00;
  localparam logic [7:0] TABLE_HIGH_RST  = 8'h00;
  localparam logic [7:0] TABLE_LATCH_RST = 8'h00;

  // ==========================================================================
  // status field positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF  = 1;
  localparam int FLAG_NULL  = 2;
  localparam int FLAG_WRAP  = 3;
  localparam int FLAG_SBOR  = 4;
  localparam int FLAG_CHAIN = 5;

  // ==========================================================================
  // data constants
  localparam logic [7:0] ALL_ONES  = 8'hff;
  localparam logic [7:0] LAST_PAGE = 8'hff;

  // ==========================================================================
  // operations
  typedef enum logic [4:0] {
    OP_ROTATE_RIGHT_CARRY_TO_ACC      = 5'h00,
    OP_SUBTRACT_WITH_BORROW           = 5'h01,
    OP_SUBTRACT_WITH_BORROW_TO_MEM    = 5'h02,
    OP_PLAIN_SUBTRACT                 = 5'h03,
    OP_PLAIN_SUBTRACT_TO_MEM          = 5'h04,
    OP_DECREMENT_SKIP_IF_NULL         = 5'h05,
    OP_DECREMENT_SKIP_IF_NULL_TO_ACC  = 5'h06,
    OP_INCREMENT_SKIP_IF_NULL         = 5'h07,
    OP_INCREMENT_SKIP_IF_NULL_TO_ACC  = 5'h08,
    OP_FORCE_ONES                     = 5'h09,
    OP_FORCE_ONES_BIT                 = 5'h0a,
    OP_SKIP_IF_NONNULL                = 5'h0b,
    OP_SKIP_IF_NONNULL_BIT            = 5'h0c,
    OP_SKIP_IF_NULL                   = 5'h0d,
    OP_SKIP_IF_NULL_BIT               = 5'h0e,
    OP_COPY_AND_SKIP_IF_NULL          = 5'h0f,
    OP_NIBBLE_EXCHANGE                = 5'h10,
    OP_NIBBLE_EXCHANGE_TO_ACC         = 5'h11,
    OP_TABLE_READ_CURRENT_PAGE        = 5'h12,
    OP_TABLE_READ_LAST_PAGE           = 5'h13,
    OP_TABLE_READ_PREINCREMENT        = 5'h14,
    OP_TABLE_READ_PREINCREMENT_LAST_PAGE = 5'h15,
    OP_EXCLUSIVE_OR_TO_ACC            = 5'h16,
    OP_EXCLUSIVE_OR_TO_MEM            = 5'h17
  } edm_op_type;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_MEM_READ  = 3'h1,
    ST_MEM_WAIT  = 3'h2,
    ST_PROG_READ = 3'h3,
    ST_PROG_WAIT = 3'h4,
    ST_DUMMY     = 3'h5
  } edm_state_type;

endpackage : edm_pkg

// ### src/edm_alu_if.sv
// interface: operands and results between the sequencing core and the alu
`timescale 1ns/1ps
interface edm_alu_if;
  import edm_pkg::*;
  edm_op_type  op;
  logic [7:0]  acc;
  logic [7:0]  mem;
  logic [2:0]  bitSel;
  logic [5:0]  flags;
  logic [7:0]  result;
  logic [5:0]  flagsNext;
  logic        wrMem;
  logic        wrAcc;
  logic        skip;
  modport alu  (input op, acc, mem, bitSel, flags,
                output result, flagsNext, wrMem, wrAcc, skip);
  modport core (output op, acc, mem, bitSel, flags,
                input result, flagsNext, wrMem, wrAcc, skip);
endinterface : edm_alu_if

// ### src/edm_alu.sv
// combinational alu for the extended data-memory operations
`timescale 1ns/1ps
module edm_alu (
  edm_alu_if.alu a
);
  import edm_pkg::*;

  logic [8:0] diff;
  logic [4:0] lowDiff;
  logic       carryIn;
  logic       isSub;
  logic       wrapBit;
  logic [7:0] incVal;
  logic [7:0] decVal;
  logic [7:0] bitMask;
  logic       bitHit;

  // ==========================================================================
  // shared arithmetic
  always_comb begin
    isSub   = (a.op == OP_SUBTRACT_WITH_BORROW) || (a.op == OP_SUBTRACT_WITH_BORROW_TO_MEM)
           || (a.op == OP_PLAIN_SUBTRACT) || (a.op == OP_PLAIN_SUBTRACT_TO_MEM);
    carryIn = ((a.op == OP_SUBTRACT_WITH_BORROW) || (a.op == OP_SUBTRACT_WITH_BORROW_TO_MEM))
            ? a.flags[FLAG_CARRY] : 1'b1;
    diff    = {1'b0, a.acc} + {1'b0, ~a.mem} + {8'h00, carryIn};
    lowDiff = {1'b0, a.acc[3:0]} + {1'b0, ~a.mem[3:0]} + {4'h0, carryIn};
    wrapBit = (a.acc[7] ^ a.mem[7]) & (diff[7] ^ a.acc[7]);
    incVal  = a.mem + 8'h01;
    decVal  = a.mem - 8'h01;
    bitMask = 8'h01 << a.bitSel;
    bitHit  = |(a.mem & bitMask);
  end

  // ==========================================================================
  // per-operation result
  always_comb begin
    a.result    = a.mem;
    a.flagsNext = a.flags;
    a.wrMem     = 1'b0;
    a.wrAcc     = 1'b0;
    a.skip      = 1'b0;
    if (isSub) begin
      a.result                = diff[7:0];
      a.flagsNext[FLAG_CARRY] = diff[8];
      a.flagsNext[FLAG_HALF]  = lowDiff[4];
      a.flagsNext[FLAG_NULL]  = (diff[7:0] == 8'h00);
      a.flagsNext[FLAG_WRAP]  = wrapBit;
      a.flagsNext[FLAG_SBOR]  = ~(wrapBit ^ diff[7]);
      a.flagsNext[FLAG_CHAIN] = (a.op == OP_PLAIN_SUBTRACT || a.op == OP_PLAIN_SUBTRACT_TO_MEM)
                              ? (diff[7:0] == 8'h00)
                              : ((diff[7:0] == 8'h00) & a.flags[FLAG_CHAIN]);
    end
    unique case (a.op)
      OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        a.result                = {a.flags[FLAG_CARRY], a.mem[7:1]};
        a.flagsNext[FLAG_CARRY] = a.mem[0];
        a.wrAcc                 = 1'b1;
      end
      OP_SUBTRACT_WITH_BORROW, OP_PLAIN_SUBTRACT: a.wrAcc = 1'b1;
      OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_PLAIN_SUBTRACT_TO_MEM: a.wrMem = 1'b1;
      OP_DECREMENT_SKIP_IF_NULL: begin
        a.result = decVal;
        a.wrMem  = 1'b1;
        a.skip   = (decVal == 8'h00);
      end
      OP_DECREMENT_SKIP_IF_NULL_TO_ACC: begin
        a.result = decVal;
        a.wrAcc  = 1'b1;
        a.skip   = (decVal == 8'h00);
      end
      OP_INCREMENT_SKIP_IF_NULL: begin
        a.result = incVal;
        a.wrMem  = 1'b1;
        a.skip   = (incVal == 8'h00);
      end
      OP_INCREMENT_SKIP_IF_NULL_TO_ACC: begin
        a.result = incVal;
        a.wrAcc  = 1'b1;
        a.skip   = (incVal == 8'h00);
      end
      OP_FORCE_ONES: begin
        a.result = ALL_ONES;
        a.wrMem  = 1'b1;
      end
      OP_FORCE_ONES_BIT: begin
        a.result = a.mem | bitMask;
        a.wrMem  = 1'b1;
      end
      OP_SKIP_IF_NONNULL:     a.skip = (a.mem != 8'h00);
      OP_SKIP_IF_NONNULL_BIT: a.skip = bitHit;
      OP_SKIP_IF_NULL:        a.skip = (a.mem == 8'h00);
      OP_SKIP_IF_NULL_BIT:    a.skip = ~bitHit;
      OP_COPY_AND_SKIP_IF_NULL: begin
        a.wrAcc = 1'b1;
        a.skip  = (a.mem == 8'h00);
      end
      OP_NIBBLE_EXCHANGE: begin
        a.result = {a.mem[3:0], a.mem[7:4]};
        a.wrMem  = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_ACC: begin
        a.result = {a.mem[3:0], a.mem[7:4]};
        a.wrAcc  = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEM: begin
        a.result               = a.acc ^ a.mem;
        a.flagsNext[FLAG_NULL] = ((a.acc ^ a.mem) == 8'h00);
        a.wrAcc                = (a.op == OP_EXCLUSIVE_OR_TO_ACC);
        a.wrMem                = (a.op == OP_EXCLUSIVE_OR_TO_MEM);
      end
      default: ;
    endcase
  end

endmodule : edm_alu

// ### src/edm_datapath.sv
// top: sequencing, accumulator, status, table pointers and register port
// Function
// - rotate right through carry into accumulator
// - borrow subtract, six flags, acc or memory
// - carry clear if negative, else set
// - plain subtract, no carry in, same flags
// - decrement memory, skip on zero, no flags
// - decrement into accumulator, skip on zero
// - increment memory, skip on zero, no flags
// - increment into accumulator, skip on zero
// - skip inserts one dummy slot, one extra cycle
// - byte set writes all ones
// - bit set forces only chosen bit
// - skip when byte or bit nonzero
// - skip when byte or bit zero
// - copy to accumulator, skip if zero
// - swap nibbles in memory or accumulator
// - table read current page to memory, latch
// - table read last page to memory, latch
// - pre-increment low pointer, read full pointer
// - pre-increment low pointer, read last page
// - xor into acc or memory, null flag
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module edm_datapath
  import edm_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    opStart,
  input  wire edm_pkg::edm_op_type     opCode,
  input  wire logic [7:0]              opMemAddr,
  input  wire logic [2:0]              opBitSel,
  input  wire logic [7:0]              pcPage,
  output logic                         memRdEn,
  output logic [edm_pkg::MEM_ADDR_W-1:0] memAddr,
  input  wire logic [7:0]              memRdData,
  output logic                         memWrEn,
  output logic [7:0]                   memWrData,
  output logic                         progRdEn,
  output logic [edm_pkg::PROG_W-1:0]   progAddr,
  input  wire logic [edm_pkg::PROG_W-1:0] progRdData,
  input  wire logic [edm_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic [7:0]                   regRdData,
  output logic                         busy,
  output logic                         opDone,
  output logic                         skipTaken,
  output logic                         dummySlot,
  output logic [7:0]                   accOut,
  output logic [edm_pkg::FLAG_W-1:0]   flagsOut
);
  import edm_pkg::*;

  edm_state_type state_r,      state_nxt;
  edm_op_type    op_r,         op_nxt;
  logic [2:0]    bit_r,        bit_nxt;
  logic [7:0]    memAddr_r,    memAddr_nxt;
  logic          memRdEn_r,    memRdEn_nxt;
  logic          memWrEn_r,    memWrEn_nxt;
  logic [7:0]    memWrData_r,  memWrData_nxt;
  logic          progRdEn_r,   progRdEn_nxt;
  logic [15:0]   progAddr_r,   progAddr_nxt;
  logic [7:0]    acc_r,        acc_nxt;
  logic [5:0]    flags_r,      flags_nxt;
  logic [7:0]    tableLow_r,   tableLow_nxt;
  logic [7:0]    tableHigh_r,  tableHigh_nxt;
  logic [7:0]    tableLatch_r, tableLatch_nxt;
  logic [7:0]    rdData_r,     rdData_nxt;
  logic          done_r,       done_nxt;
  logic          skip_r,       skip_nxt;
  logic          dummy_r,      dummy_nxt;
  logic          busy_r,       busy_nxt;
  logic [7:0]    lowPlusOne;
  logic          execAcc;
  logic          execFlags;

  edm_alu_if aluBus ();

  edm_alu u_alu (
    .a (aluBus.alu)
  );

  assign aluBus.op     = op_r;
  assign aluBus.acc    = acc_r;
  assign aluBus.mem    = memRdData;
  assign aluBus.bitSel = bit_r;
  assign aluBus.flags  = flags_r;

  // ==========================================================================
  // sequencer next state
  always_comb begin
    state_nxt      = state_r;
    op_nxt         = op_r;
    bit_nxt        = bit_r;
    memAddr_nxt    = memAddr_r;
    memRdEn_nxt    = 1'b0;
    memWrEn_nxt    = 1'b0;
    memWrData_nxt  = memWrData_r;
    progRdEn_nxt   = 1'b0;
    progAddr_nxt   = progAddr_r;
    acc_nxt        = acc_r;
    flags_nxt      = flags_r;
    tableLow_nxt   = tableLow_r;
    tableHigh_nxt  = tableHigh_r;
    tableLatch_nxt = tableLatch_r;
    done_nxt       = 1'b0;
    skip_nxt       = 1'b0;
    dummy_nxt      = 1'b0;
    execAcc        = 1'b0;
    execFlags      = 1'b0;
    lowPlusOne     = tableLow_r + 8'h01;

    unique case (state_r)
      ST_IDLE: begin
        if (opStart) begin
          op_nxt      = opCode;
          bit_nxt     = opBitSel;
          memAddr_nxt = opMemAddr;
          unique case (opCode)
            OP_TABLE_READ_CURRENT_PAGE: begin
              progAddr_nxt = {pcPage, tableLow_r};
              state_nxt    = ST_PROG_READ;
              progRdEn_nxt = 1'b1;
            end
            OP_TABLE_READ_LAST_PAGE: begin
              progAddr_nxt = {LAST_PAGE, tableLow_r};
              state_nxt    = ST_PROG_READ;
              progRdEn_nxt = 1'b1;
            end
            OP_TABLE_READ_PREINCREMENT: begin
              tableLow_nxt = lowPlusOne;
              progAddr_nxt = {tableHigh_r, lowPlusOne};
              state_nxt    = ST_PROG_READ;
              progRdEn_nxt = 1'b1;
            end
            OP_TABLE_READ_PREINCREMENT_LAST_PAGE: begin
              tableLow_nxt = lowPlusOne;
              progAddr_nxt = {LAST_PAGE, lowPlusOne};
              state_nxt    = ST_PROG_READ;
              progRdEn_nxt = 1'b1;
            end
            default: begin
              state_nxt   = ST_MEM_READ;
              memRdEn_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_MEM_READ:  state_nxt = ST_MEM_WAIT;
      ST_MEM_WAIT: begin
        memWrEn_nxt   = aluBus.wrMem;
        memWrData_nxt = aluBus.result;
        execAcc       = aluBus.wrAcc;
        execFlags     = 1'b1;
        if (aluBus.wrAcc) begin
          acc_nxt = aluBus.result;
        end
        flags_nxt = aluBus.flagsNext;
        skip_nxt  = aluBus.skip;
        if (aluBus.skip) begin
          state_nxt = ST_DUMMY;
          dummy_nxt = 1'b1;
        end else begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      ST_PROG_READ: state_nxt = ST_PROG_WAIT;
      ST_PROG_WAIT: begin
        memWrEn_nxt    = 1'b1;
        memWrData_nxt  = progRdData[7:0];
        tableLatch_nxt = progRdData[15:8];
        state_nxt      = ST_IDLE;
        done_nxt       = 1'b1;
      end
      ST_DUMMY: begin
        state_nxt = ST_IDLE;
        done_nxt  = 1'b1;
      end
      default: state_nxt = ST_IDLE;
    endcase
    busy_nxt = (state_nxt != ST_IDLE);

    // ========================================================================
    // register port writes; datapath updates win
    if (regWr) begin
      unique case (regAddr)
        REG_ACC:         if (!execAcc) acc_nxt = regWrData;
        REG_STATUS:      if (!execFlags) flags_nxt = regWrData[5:0];
        REG_TABLE_LOW:   if (state_r != ST_IDLE || !opStart) tableLow_nxt = regWrData;
        REG_TABLE_HIGH:  tableHigh_nxt = regWrData;
        REG_TABLE_LATCH: if (state_r != ST_PROG_WAIT) tableLatch_nxt = regWrData;
        default: ;
      endcase
    end

    rdData_nxt = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        REG_ACC:         rdData_nxt = acc_r;
        REG_STATUS:      rdData_nxt = {2'b00, flags_r};
        REG_TABLE_LOW:   rdData_nxt = tableLow_r;
        REG_TABLE_HIGH:  rdData_nxt = tableHigh_r;
        REG_TABLE_LATCH: rdData_nxt = tableLatch_r;
        default:         rdData_nxt = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      op_r         <= OP_ROTATE_RIGHT_CARRY_TO_ACC;
      bit_r        <= 3'h0;
      memAddr_r    <= 8'h00;
      memRdEn_r    <= 1'b0;
      memWrEn_r    <= 1'b0;
      memWrData_r  <= 8'h00;
      progRdEn_r   <= 1'b0;
      progAddr_r   <= 16'h0000;
      acc_r        <= ACC_RST;
      flags_r      <= STATUS_RST;
      tableLow_r   <= TABLE_LOW_RST;
      tableHigh_r  <= TABLE_HIGH_RST;
      tableLatch_r <= TABLE_LATCH_RST;
      rdData_r     <= 8'h00;
      done_r       <= 1'b0;
      skip_r       <= 1'b0;
      dummy_r      <= 1'b0;
      busy_r       <= 1'b0;
    end else if (ce) begin
      state_r      <= state_nxt;
      op_r         <= op_nxt;
      bit_r        <= bit_nxt;
      memAddr_r    <= memAddr_nxt;
      memRdEn_r    <= memRdEn_nxt;
      memWrEn_r    <= memWrEn_nxt;
      memWrData_r  <= memWrData_nxt;
      progRdEn_r   <= progRdEn_nxt;
      progAddr_r   <= progAddr_nxt;
      acc_r        <= acc_nxt;
      flags_r      <= flags_nxt;
      tableLow_r   <= tableLow_nxt;
      tableHigh_r  <= tableHigh_nxt;
      tableLatch_r <= tableLatch_nxt;
      rdData_r     <= rdData_nxt;
      done_r       <= done_nxt;
      skip_r       <= skip_nxt;
      dummy_r      <= dummy_nxt;
      busy_r       <= busy_nxt;
    end
  end

  assign memRdEn   = memRdEn_r;
  assign memAddr   = memAddr_r;
  assign memWrEn   = memWrEn_r;
  assign memWrData = memWrData_r;
  assign progRdEn  = progRdEn_r;
  assign progAddr  = progAddr_r;
  assign regRdData = rdData_r;
  assign busy      = busy_r;
  assign opDone    = done_r;
  assign skipTaken = skip_r;
  assign dummySlot = dummy_r;
  assign accOut    = acc_r;
  assign flagsOut  = flags_r;

  // ==========================================================================
  // checks
  rotate_acc_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_ROTATE_RIGHT_CARRY_TO_ACC |=>
      accOut == {$past(flagsOut[FLAG_CARRY]), $past(memRdData[7:1])}
      && flagsOut[FLAG_CARRY] == $past(memRdData[0]) && !memWrEn)
    else $error("rotate through carry wrong");

  sub_carry_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT
      && (op_r == OP_PLAIN_SUBTRACT || op_r == OP_PLAIN_SUBTRACT_TO_MEM) |=>
      flagsOut[FLAG_CARRY] == ($past(accOut) >= $past(memRdData)))
    else $error("subtract carry wrong");

  sub_result_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_SUBTRACT_WITH_BORROW_TO_MEM |=>
      memWrEn && memWrData == 8'($past(accOut) - $past(memRdData)
        - {7'h00, ~$past(flagsOut[FLAG_CARRY])}))
    else $error("borrow subtract result wrong");

  skip_dummy_a: assert property (@(posedge clock) disable iff (rst)
    ce && skipTaken |-> dummySlot && !opDone ##1 opDone && !busy)
    else $error("skip without dummy slot");

  dec_skip_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_DECREMENT_SKIP_IF_NULL |=>
      memWrEn && memWrData == 8'($past(memRdData) - 8'h01)
      && skipTaken == ($past(memRdData) == 8'h01) && $stable(flagsOut))
    else $error("decrement skip wrong");

  force_ones_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_FORCE_ONES |=>
      memWrEn && memWrData == ALL_ONES && $stable(flagsOut))
    else $error("byte set wrong");

  xor_null_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_EXCLUSIVE_OR_TO_ACC |=>
      accOut == ($past(accOut) ^ $past(memRdData))
      && flagsOut[FLAG_NULL] == (accOut == 8'h00)
      && flagsOut[FLAG_CARRY] == $past(flagsOut[FLAG_CARRY]))
    else $error("xor wrong");

  table_latch_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_PROG_WAIT |=>
      memWrEn && memWrData == $past(progRdData[7:0])
      && tableLatch_r == $past(progRdData[15:8]) && flagsOut == $past(flagsOut))
    else $error("table read store wrong");

  table_preinc_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_IDLE && opStart && opCode == OP_TABLE_READ_PREINCREMENT |=>
      progAddr == {tableHigh_r, tableLow_r} && tableLow_r == 8'($past(tableLow_r) + 8'h01))
    else $error("pre-increment table read wrong");

  swap_acc_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_NIBBLE_EXCHANGE_TO_ACC |=>
      accOut == {$past(memRdData[3:0]), $past(memRdData[7:4])} && !memWrEn)
    else $error("nibble swap wrong");

  bit_set_a: assert property (@(posedge clock) disable iff (rst)
    ce && state_r == ST_MEM_WAIT && op_r == OP_FORCE_ONES_BIT |=>
      memWrEn && memWrData == ($past(memRdData) | (8'h01 << $past(bit_r)))
      && $stable(flagsOut))
    else $error("bit set wrong");

endmodule : edm_datapath

// ### sim/edm_mem_model.sv
// partner: data memory and program memory behind the datapath
`timescale 1ns/1ps
module edm_mem_model (
  input  wire logic        clock,
  input  wire logic        memRdEn,
  input  wire logic [7:0]  memAddr,
  input  wire logic        memWrEn,
  input  wire logic [7:0]  memWrData,
  output logic      [7:0]  memRdData,
  input  wire logic        progRdEn,
  input  wire logic [15:0] progAddr,
  output logic      [15:0] progRdData
);
  logic [7:0] mem [256];

  // ==========================================================================
  // storage: byte i holds i xor 5a, program word is its address xor c3a5
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    memRdData = 8'h00;
    progRdData = 16'h0000;
  end

  // ==========================================================================
  // answers one cycle after the read pulse, toggled junk otherwise
  always @(posedge clock) begin
    memRdData <= memRdEn ? mem[memAddr] : ~memRdData;
    progRdData <= progRdEn ? progAddr ^ 16'hc3a5 : ~progRdData;
    if (memWrEn) mem[memAddr] <= memWrData;
  end
endmodule : edm_mem_model

// ### sim/extended_data_memory_ops_bench.sv
// bench: runs operations and register accesses against a reference model
`timescale 1ns/1ps
module extended_data_memory_ops_bench;
  import edm_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, ce = 1'b1, opStart = 1'b0;
  logic        regWr = 1'b0, regRd = 1'b0;
  edm_op_type  opCode = OP_ROTATE_RIGHT_CARRY_TO_ACC;
  logic [7:0]  opMemAddr = 8'h00, pcPage = 8'h00, regWrData = 8'h00;
  logic [2:0]  opBitSel = 3'h0, regAddr = 3'h0;
  logic [7:0]  memRdData, memAddr, memWrData, regRdData, accOut, rd;
  logic [15:0] progAddr, progRdData;
  logic        memRdEn, memWrEn, progRdEn, busy, opDone, skipTaken, dummySlot;
  logic [5:0]  flagsOut, rflg = 6'h00;
  logic [7:0]  racc = 8'h00, rlow = 8'h00, rhigh = 8'h00, rlatch = 8'h00;
  logic [7:0]  rmem [256];
  logic [31:0] seed = 32'h3e9a6d0d;
  int          num_errors = 0, cmp_count = 0, cycles = 0;

  always #10 clock = ~clock;

  edm_datapath u_dut (.clock, .rst, .ce, .opStart, .opCode, .opMemAddr, .opBitSel,
    .pcPage, .memRdEn, .memAddr, .memRdData, .memWrEn, .memWrData, .progRdEn,
    .progAddr, .progRdData, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .busy, .opDone, .skipTaken, .dummySlot, .accOut, .flagsOut);
  edm_mem_model u_mem (.clock, .memRdEn, .memAddr, .memWrEn, .memWrData,
    .memRdData, .progRdEn, .progAddr, .progRdData);

  // ==========================================================================
  // helpers
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    rd = regRdData;
  endtask : rd_reg

  task automatic set_regs(input logic [31:0] v);
    racc = v[7:0];
    rflg = v[13:8];
    rlow = v[23:16];
    rhigh = v[31:24];
    wr_reg(REG_ACC, racc);
    wr_reg(REG_STATUS, {2'b11, rflg});
    wr_reg(REG_TABLE_LOW, rlow);
    wr_reg(REG_TABLE_HIGH, rhigh);
  endtask : set_regs

  // ==========================================================================
  // one operation: model, drive, compare
  task automatic do_op(input edm_op_type op, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] pg);
    logic [7:0] m, res, p;
    logic [15:0] w;
    logic sk, wa, wm, ov, sb;
    int d, h, n, k;
    m = rmem[a];
    sk = 1'b0;
    wa = 1'b0;
    wm = 1'b0;
    res = m;
    sb = op inside {OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM};
    case (op)
      OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        res = {rflg[FLAG_CARRY], m[7:1]};
        rflg[FLAG_CARRY] = m[0];
        wa = 1'b1;
      end
      OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_PLAIN_SUBTRACT,
      OP_PLAIN_SUBTRACT_TO_MEM: begin
        n = sb ? int'(!rflg[FLAG_CARRY]) : 0;
        d = int'(racc) - int'(m) - n;
        h = int'(racc[3:0]) - int'(m[3:0]) - n;
        res = d[7:0];
        ov = (racc[7] != m[7]) && (res[7] != racc[7]);
        rflg = {(res == 8'h00) && (rflg[5] || !sb), ~(ov ^ res[7]), ov, res == 8'h00,
                h >= 0, d >= 0};
        wa = op inside {OP_SUBTRACT_WITH_BORROW, OP_PLAIN_SUBTRACT};
        wm = !wa;
      end
      OP_DECREMENT_SKIP_IF_NULL, OP_DECREMENT_SKIP_IF_NULL_TO_ACC: begin
        res = m - 8'h01;
        sk = res == 8'h00;
        wm = op == OP_DECREMENT_SKIP_IF_NULL;
        wa = !wm;
      end
      OP_INCREMENT_SKIP_IF_NULL, OP_INCREMENT_SKIP_IF_NULL_TO_ACC: begin
        res = m + 8'h01;
        sk = res == 8'h00;
        wm = op == OP_INCREMENT_SKIP_IF_NULL;
        wa = !wm;
      end
      OP_FORCE_ONES: {res, wm} = {ALL_ONES, 1'b1};
      OP_FORCE_ONES_BIT: {res, wm} = {m | (8'h01 << b), 1'b1};
      OP_SKIP_IF_NONNULL: sk = m != 8'h00;
      OP_SKIP_IF_NONNULL_BIT: sk = m[b];
      OP_SKIP_IF_NULL: sk = m == 8'h00;
      OP_SKIP_IF_NULL_BIT: sk = !m[b];
      OP_COPY_AND_SKIP_IF_NULL: {sk, wa} = {m == 8'h00, 1'b1};
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_ACC: begin
        res = {m[3:0], m[7:4]};
        wm = op == OP_NIBBLE_EXCHANGE;
        wa = !wm;
      end
      OP_EXCLUSIVE_OR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEM: begin
        res = racc ^ m;
        rflg[FLAG_NULL] = res == 8'h00;
        wa = op == OP_EXCLUSIVE_OR_TO_ACC;
        wm = !wa;
      end
      default: begin
        if (op inside {OP_TABLE_READ_PREINCREMENT, OP_TABLE_READ_PREINCREMENT_LAST_PAGE}) rlow++;
        p = op == OP_TABLE_READ_PREINCREMENT ? rhigh : LAST_PAGE;
        if (op == OP_TABLE_READ_CURRENT_PAGE) p = pg;
        w = {p, rlow} ^ 16'hc3a5;
        res = w[7:0];
        rlatch = w[15:8];
        wm = 1'b1;
      end
    endcase
    if (wa) racc = res;
    if (wm) rmem[a] = res;
    @(posedge clock);
    opStart <= 1'b1;
    opCode <= op;
    opMemAddr <= a;
    opBitSel <= b;
    pcPage <= pg;
    @(posedge clock);
    opStart <= 1'b0;
    k = 0;
    n = 0;
    do begin
      @(negedge clock);
      k++;
      n += int'(skipTaken === 1'b1 && dummySlot === 1'b1);
    end while (opDone !== 1'b1 && k < 20);
    check(16'(k), sk ? 16'h4 : 16'h3, "latency");
    check(16'(n), 16'(sk), "skip slot");
    check(16'(busy), 16'h0, "busy");
    check(16'(accOut), 16'(racc), "acc");
    check(16'(flagsOut), 16'(rflg), "flags");
    rd_reg(REG_TABLE_LATCH);
    check(16'(rd), 16'(rlatch), "latch");
    rd_reg(REG_TABLE_LOW);
    check(16'(rd), 16'(rlow), "low pointer");
    check(16'(u_mem.mem[a]), 16'(rmem[a]), "memory");
  endtask : do_op

  // ==========================================================================
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) rmem[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_reg(3'(i));
      check(16'(rd), 16'h0, "reset read");
    end
    wr_reg(3'h7, 8'h55);
    rd_reg(3'h7);
    check(16'(rd), 16'h0, "unmapped");
    set_regs(32'h0081_f3c5);
    rd_reg(REG_STATUS);
    check(16'(rd), 16'(rflg), "status");
    for (int i = 0; i < 72; i++) begin
      do_op(edm_op_type'(i % 24), i < 24 ? 8'h5a : (i < 48 ? 8'ha5 : 8'h5b), 3'(i), 8'h12);
    end
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      if (seed[31:29] == 3'h0) set_regs(seed);
      do_op(edm_op_type'(seed[4:0] % 5'h18), seed[12:5], seed[15:13], seed[23:16]);
    end
    print_verdict();
  end
endmodule : extended_data_memory_ops_bench
